//--- logic/tja_pkg.sv
// Constants, types and helpers for the tributary justification adapter
// Behaviour
// - Majority zero takes J as data
// - Sink store written by gapped clock
// - Sink store read by smoothed tracking clock
// - Sink store absorbs jitter and 30 ppm
// - Sink recovers within bound after step
// - Sink extracts only its own slot
// - Inactive sink sends ones, reports nothing in status (SSF output still follows fail)
// - AIS forces ones within 800 us
// - AIS clear restores data within 800 us
// - Source inserts tributary into slot frame
// - Source store written by tributary clock
// - Source reads on aggregate timing, decisions
// - Justification skips one read, J empty
// - Source error free within 30 ppm
// - Source emits control groups in place
// - Source writes only its own slot
// - Source drives access point only active
package tja_pkg;

  // Aggregate frame geometry
  localparam int FRAME_BITS = 1536;
  localparam int SET_BITS = 384;
  localparam int OVH_BITS = 12;
  localparam int CBIT_END = 4;
  localparam int JBIT_END = 8;
  localparam int SLOT_COUNT = 4;
  localparam int POS_W = 11;
  localparam logic [POS_W-1:0] POS_LAST = 11'h5FF;
  localparam logic [POS_W-1:0] SET1_START = 11'h180;
  localparam logic [POS_W-1:0] SET2_START = 11'h300;
  localparam logic [POS_W-1:0] SET3_START = 11'h480;

  // Timing
  localparam longint unsigned CLK_HZ = 64'd250000000;
  localparam longint unsigned TRIB_RATE_HZ = 64'd8448000;
  localparam logic [31:0] NCO_STEP = 32'((TRIB_RATE_HZ << 32) / CLK_HZ);
  localparam int AIS_LIMIT_US = 800;
  localparam int CLK_MHZ = 250;
  localparam int AIS_LIMIT_CYC = AIS_LIMIT_US * CLK_MHZ;

  // APB map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_SRC_ACT = 0;
  localparam int CTRL_SNK_ACT = 1;
  localparam int ST_SSF = 0;
  localparam int ST_JUST = 1;
  localparam int ST_SNK_FILL = 8;
  localparam int ST_SRC_FILL = 16;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  typedef enum logic [1:0] {K_OVH, K_CBIT, K_JBIT, K_DATA} tja_kind_t;

  // Classify a frame position
  function automatic tja_kind_t tja_kind(input logic [POS_W-1:0] p);
    logic [POS_W-1:0] off;
    off = p;
    if (p >= SET3_START)
      off = p - SET3_START;
    else if (p >= SET2_START)
      off = p - SET2_START;
    else if (p >= SET1_START)
      off = p - SET1_START;
    if (p < SET1_START)
      return (off < POS_W'(OVH_BITS)) ? K_OVH : K_DATA;
    if (off < POS_W'(CBIT_END))
      return K_CBIT;
    if (p >= SET3_START && off < POS_W'(JBIT_END))
      return K_JBIT;
    return K_DATA;
  endfunction

  // Which of the three control bits a position carries
  function automatic logic [1:0] tja_cidx(input logic [POS_W-1:0] p);
    if (p >= SET3_START)
      return 2'h2;
    if (p >= SET2_START)
      return 2'h1;
    return 2'h0;
  endfunction

  function automatic logic tja_major(input logic [2:0] c);
    return (c[0] & c[1]) | (c[0] & c[2]) | (c[1] & c[2]);
  endfunction

endpackage

//--- logic/tja_store_if.sv
// Port bundle between the adapter and one elastic store
interface tja_store_if #(parameter int AW = 6);
  logic flush;
  logic wr_en;
  logic wr_data;
  logic rd_en;
  logic rd_data;
  logic [AW:0] fill;
  logic full;
  logic empty;
  modport store (input flush, input wr_en, input wr_data, input rd_en,
                 output rd_data, output fill, output full, output empty);
  modport user (output flush, output wr_en, output wr_data, output rd_en,
                input rd_data, input fill, input full, input empty);
endinterface

//--- logic/tja_store.sv
// One-bit elastic store with fill level
module tja_store
  import tja_pkg::*;
#(
  parameter int AW = 6
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // User side
  tja_store_if.store st
);

  logic mem [2**AW];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;

  assign st.fill = wp_r - rp_r;
  assign st.full = (st.fill == (AW+1)'(2**AW));
  assign st.empty = (wp_r == rp_r);
  assign st.rd_data = mem[rp_r[AW-1:0]];

  always_ff @(posedge sys_clk)
  begin
    if (st.wr_en && !st.full)
      mem[wp_r[AW-1:0]] <= st.wr_data;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      wp_r <= '0;
    else if (st.flush)
      wp_r <= '0;
    else if (st.wr_en && !st.full)
      wp_r <= wp_r + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rp_r <= '0;
    else if (st.flush)
      rp_r <= '0;
    else if (st.rd_en && !st.empty)
      rp_r <= rp_r + 1'b1;
  end

endmodule // tja_store

//--- logic/tja_adapter.sv
// Tributary justification adapter: source and sink with APB control
module tja_adapter
  import tja_pkg::*;
#(
  parameter int SLOT_INDEX = 1,
  parameter int STORE_AW = 6,
  parameter int GAIN_SHIFT = 12
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Aggregate receive side
  input wire logic aggregate_payload_data,
  input wire logic aggregate_payload_clock,
  input wire logic aggregate_frame_start,
  input wire logic trail_signal_fail_in,
  // Recovered tributary
  output logic tributary_data_out,
  output logic tributary_clock_out,
  output logic server_signal_fail_out,
  output logic ais_insert_action,
  // Tributary input
  input wire logic tributary_data_in,
  input wire logic tributary_clock_in,
  // Aggregate transmit side
  input wire logic aggregate_timing_clock,
  input wire logic aggregate_timing_frame_start,
  output logic agg_out_data,
  output logic agg_out_drive_n
);

  // Refuse parameters the logic cannot serve
  if (SLOT_INDEX < 1 || SLOT_INDEX > SLOT_COUNT)
  begin : g_bad_slot
    $error("SLOT_INDEX out of range");
  end
  if (STORE_AW < 3 || STORE_AW > 7)
  begin : g_bad_aw
    $error("STORE_AW out of range");
  end
  if (GAIN_SHIFT < 1 || GAIN_SHIFT > 20)
  begin : g_bad_gain
    $error("GAIN_SHIFT out of range");
  end

  localparam logic [1:0] LANE = 2'(SLOT_INDEX - 1);
  localparam logic [STORE_AW:0] HALF = (STORE_AW+1)'(2**(STORE_AW-1));

  tja_store_if #(.AW(STORE_AW)) snk_st ();
  tja_store_if #(.AW(STORE_AW)) src_st ();

  tja_store #(.AW(STORE_AW)) u_snk_store (.sys_clk(sys_clk), .reset_n(reset_n), .st(snk_st));
  tja_store #(.AW(STORE_AW)) u_src_store (.sys_clk(sys_clk), .reset_n(reset_n), .st(src_st));

  // Control register and APB
  logic [1:0] ctrl_r;
  logic src_active;
  logic snk_active;
  logic apb_hit;
  assign src_active = ctrl_r[CTRL_SRC_ACT];
  assign snk_active = ctrl_r[CTRL_SNK_ACT];
  assign apb_hit = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !apb_hit;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_r <= CTRL_RESET;
    else if (psel && penable && pwrite && paddr == ADDR_CTRL)
      ctrl_r <= pwdata[1:0];
  end

  logic src_just_r;
  logic [31:0] status;
  always_comb
  begin
    status = '0;
    // Inactive sink reports nothing
    // status suppression
    if (snk_active)
    begin
      status[ST_SSF] = server_signal_fail_out;
      status[ST_SNK_FILL +: STORE_AW+1] = snk_st.fill;
    end
    status[ST_JUST] = src_just_r;
    status[ST_SRC_FILL +: STORE_AW+1] = src_st.fill;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= (paddr == ADDR_CTRL) ? {30'h0, ctrl_r} : (paddr == ADDR_STATUS) ? status : '0;
  end

  // Sink: frame position
  logic [POS_W-1:0] rx_pos_r;
  logic [POS_W-1:0] rx_pos;
  tja_kind_t rx_kind;
  logic rx_own;
  assign rx_pos = aggregate_frame_start ? '0 : ((rx_pos_r == POS_LAST) ? '0 : rx_pos_r + 1'b1);
  assign rx_kind = tja_kind(rx_pos);
  assign rx_own = aggregate_payload_clock && rx_pos[1:0] == LANE && snk_active;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rx_pos_r <= POS_LAST;
    else if (aggregate_payload_clock)
      rx_pos_r <= rx_pos;
  end

  logic [2:0] rx_c_r;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rx_c_r <= '0;
    else if (rx_own && rx_kind == K_CBIT)
      rx_c_r[tja_cidx(rx_pos)] <= aggregate_payload_data;
  end

  logic rx_take_j;
  assign rx_take_j = rx_own && rx_kind == K_JBIT && !tja_major(rx_c_r);

  // Gapped write into the sink store
  // gapped write
  assign snk_st.wr_en = (rx_own && rx_kind == K_DATA) || rx_take_j;
  assign snk_st.wr_data = aggregate_payload_data;
  assign snk_st.flush = !snk_active;

  // Smoothed read clock: NCO steered by fill
  // tracking read rate
  logic [31:0] nco_r;
  logic signed [33:0] fill_err;
  logic [32:0] nco_sum;
  logic [31:0] nco_step;
  always_comb
  begin
    fill_err = 34'(signed'({1'b0, snk_st.fill})) - 34'(signed'({1'b0, HALF}));
    nco_step = NCO_STEP + 32'(fill_err <<< GAIN_SHIFT);
    nco_sum = {1'b0, nco_r} + {1'b0, nco_step};
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      nco_r <= '0;
    else
      nco_r <= nco_sum[31:0];
  end

  logic rd_tick;
  assign rd_tick = nco_sum[32];
  assign snk_st.rd_en = rd_tick;

  // Signal fail propagation
  // fail to AIS and SSF
  assign ais_insert_action = trail_signal_fail_in;
  assign server_signal_fail_out = trail_signal_fail_in;

  logic force_ones;
  assign force_ones = !snk_active || ais_insert_action;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      tributary_data_out <= 1'b1;
    else if (force_ones)
      tributary_data_out <= 1'b1;
    else if (rd_tick)
      tributary_data_out <= snk_st.empty ? 1'b1 : snk_st.rd_data;
  end

  // Clock keeps running during AIS so ones hold the rate
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      tributary_clock_out <= 1'b0;
    else
      tributary_clock_out <= rd_tick;
  end

  // Source: tributary write
  // write on tributary clock
  assign src_st.wr_en = tributary_clock_in && src_active;
  assign src_st.wr_data = tributary_data_in;
  assign src_st.flush = !src_active;

  logic [POS_W-1:0] tx_pos_r;
  logic [POS_W-1:0] tx_pos;
  tja_kind_t tx_kind;
  logic tx_own;
  assign tx_pos = aggregate_timing_frame_start ? '0 : ((tx_pos_r == POS_LAST) ? '0 : tx_pos_r + 1'b1);
  assign tx_kind = tja_kind(tx_pos);
  assign tx_own = aggregate_timing_clock && tx_pos[1:0] == LANE && tx_kind != K_OVH;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      tx_pos_r <= POS_LAST;
    else if (aggregate_timing_clock)
      tx_pos_r <= tx_pos;
  end

  // Justify when the store runs low, decided at frame start
  // decision keeps store centred
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      src_just_r <= 1'b0;
    else if (aggregate_timing_clock && tx_pos == '0)
      src_just_r <= src_st.fill < HALF;
  end

  // read on timing, skip on justification
  assign src_st.rd_en = tx_own && src_active && (tx_kind == K_DATA || (tx_kind == K_JBIT && !src_just_r));

  logic tx_bit;
  always_comb
  begin
    case (tx_kind)
      K_CBIT: tx_bit = src_just_r;
      K_JBIT: tx_bit = src_just_r ? 1'b1 : (src_st.empty ? 1'b1 : src_st.rd_data);
      K_DATA: tx_bit = src_st.empty ? 1'b1 : src_st.rd_data;
      default: tx_bit = 1'b1;
    endcase
  end

  // drive only own bits while active
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      agg_out_data <= 1'b1;
      agg_out_drive_n <= 1'b1;
    end
    else if (aggregate_timing_clock)
    begin
      agg_out_data <= tx_bit;
      agg_out_drive_n <= !(tx_own && src_active);
    end
    // Release at once on deactivation, not at the next bit
    else if (!src_active)
      agg_out_drive_n <= 1'b1;
  end

  // Checks
  a_sink_maj_one: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rx_own && rx_kind == K_JBIT && tja_major(rx_c_r)) |-> !snk_st.wr_en)
    else $error("stuffed J written");
  a_sink_maj_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rx_own && rx_kind == K_JBIT && !tja_major(rx_c_r)) |-> snk_st.wr_en)
    else $error("J data dropped");
  a_sink_slot_only: assert property (@(posedge sys_clk) disable iff (!reset_n)
    snk_st.wr_en |-> rx_pos[1:0] == LANE && aggregate_payload_clock)
    else $error("foreign slot written");
  a_inactive_ones: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !snk_active |-> !status[ST_SSF] ##1 tributary_data_out)
    else $error("inactive sink not all ones");
  a_ais_ones_fast: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(ais_insert_action) |=> tributary_data_out [*2])
    else $error("AIS not applied");
  a_ais_clear_data: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($fell(ais_insert_action) && snk_active) |-> ##[1:40] (rd_tick && !force_ones)
    ##1 (tributary_data_out == $past(snk_st.rd_data) || $past(snk_st.empty)))
    else $error("data not resumed");
  a_fail_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    server_signal_fail_out == trail_signal_fail_in && ais_insert_action == trail_signal_fail_in)
    else $error("fail not propagated");
  a_src_skip_j: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (tx_own && tx_kind == K_JBIT && src_just_r) |-> !src_st.rd_en ##1 agg_out_data)
    else $error("J read on justification");
  a_src_cbits: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (tx_own && src_active && tx_kind == K_CBIT) |=> agg_out_data == src_just_r && !agg_out_drive_n)
    else $error("control bit wrong");
  a_src_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!src_active && !$past(src_active)) |-> agg_out_drive_n)
    else $error("inactive source drives");

  c_just_frame: cover property (@(posedge sys_clk) disable iff (!reset_n)
    tx_own && src_active && tx_kind == K_JBIT && src_just_r);
  c_j_taken: cover property (@(posedge sys_clk) disable iff (!reset_n) rx_take_j);
  c_ais_cycle: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(trail_signal_fail_in) ##[1:1000] $fell(trail_signal_fail_in));

endmodule // tja_adapter

//--- verification/tja_agg_model.sv
// Aggregate far side and tributary bit clock for the adapter bench
module tja_agg_model
  import tja_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Transmit aggregate from the adapter
  input wire logic agg_out_data,
  input wire logic agg_out_drive_n,
  // Aggregate strobes and loop back
  output logic aggregate_timing_clock,
  output logic aggregate_timing_frame_start,
  output logic aggregate_payload_clock,
  output logic aggregate_payload_data,
  output logic aggregate_frame_start,
  output logic [POS_W-1:0] tx_pos,
  // Tributary bit strobe
  output logic tributary_clock_in,
  // Tributary rate select
  input wire logic trib_fast
);
  logic [2:0] div_r;
  logic [1:0] grp_r;
  logic [4:0] tdiv_r;
  logic [2:0] div_end;
  logic [4:0] tdiv_end;
  logic last_r;
  // 7,7,7,8 cycles per aggregate bit, near the aggregate rate
  assign div_end = (grp_r == 2'h3) ? 3'h7 : 3'h6;
  // Fast tributary fills the store, slow one forces justification
  assign tdiv_end = trib_fast ? 5'h1A : 5'h1D;
  // Looped back one cycle after the timing strobe
  assign aggregate_timing_clock = div_r == 3'h0;
  assign aggregate_timing_frame_start = aggregate_timing_clock && tx_pos == POS_LAST;
  assign aggregate_payload_clock = div_r == 3'h1;
  assign aggregate_frame_start = aggregate_payload_clock && tx_pos == '0;
  assign aggregate_payload_data = agg_out_drive_n ? ~last_r : agg_out_data;
  assign tributary_clock_in = tdiv_r == 5'h00;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_r <= 3'h0;
      grp_r <= 2'h0;
      tdiv_r <= 5'h00;
      last_r <= 1'b0;
      tx_pos <= POS_LAST;
    end
    else
    begin
      div_r <= (div_r == div_end) ? 3'h0 : div_r + 3'h1;
      if (div_r == div_end)
        grp_r <= grp_r + 2'h1;
      tdiv_r <= (tdiv_r >= tdiv_end) ? 5'h00 : tdiv_r + 5'h01;
      if (aggregate_timing_clock)
        tx_pos <= (tx_pos == POS_LAST) ? '0 : tx_pos + 1'b1;
      if (aggregate_payload_clock)
        last_r <= aggregate_payload_data;
    end
  end
endmodule // tja_agg_model

//--- verification/tributary_justification_adapter_tb.sv
// Self-checking bench for the tributary justification adapter
module tributary_justification_adapter_tb;
  import tja_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOT = 2;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic trail_signal_fail_in = 1'b0;
  logic tributary_data_in = 1'b0;
  logic trib_fast = 1'b0;
  logic jb;
  logic [31:0] prdata, rd;
  logic pready, pslverr, rerr, tributary_data_out, tributary_clock_out;
  logic server_signal_fail_out, ais_insert_action, agg_out_data, agg_out_drive_n;
  logic aggregate_timing_clock, aggregate_timing_frame_start, aggregate_payload_clock;
  logic aggregate_payload_data, aggregate_frame_start, tributary_clock_in;
  logic [POS_W-1:0] tx_pos;
  logic [2:0] cb;
  int err_total = 0;
  int num_checks = 0;
  int n_own, n_bad, p, z, o, gmin, gmax;

  always #2 sys_clk = ~sys_clk;

  tja_adapter #(.SLOT_INDEX(SLOT)) dut (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .aggregate_payload_data, .aggregate_payload_clock, .aggregate_frame_start,
    .trail_signal_fail_in, .tributary_data_out, .tributary_clock_out, .server_signal_fail_out,
    .ais_insert_action, .tributary_data_in, .tributary_clock_in, .aggregate_timing_clock,
    .aggregate_timing_frame_start, .agg_out_data, .agg_out_drive_n);

  tja_agg_model agg (.sys_clk, .reset_n, .agg_out_data, .agg_out_drive_n, .aggregate_timing_clock,
    .aggregate_timing_frame_start, .aggregate_payload_clock, .aggregate_payload_data,
    .aggregate_frame_start, .tx_pos, .tributary_clock_in, .trib_fast);

  task automatic test_done();
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Watch one whole transmit frame
  task automatic mon_frame();
    n_own = 0;
    n_bad = 0;
    cb = 'x;
    jb = 1'bx;
    // Start at a frame boundary so all control bits share one decision
    do
      @(negedge sys_clk);
    while (aggregate_timing_frame_start !== 1'b1);
    repeat (FRAME_BITS)
    begin
      do
        @(negedge sys_clk);
      while (aggregate_payload_clock !== 1'b1);
      if (agg_out_drive_n === 1'b0)
      begin
        n_own++;
        if (tx_pos[1:0] != 2'(SLOT - 1) || tx_pos < 11'h00C)
          n_bad++;
        for (int k = 1; k < 4; k++)
          if (tx_pos == POS_W'(k * SET_BITS + SLOT - 1))
            cb[k-1] = agg_out_data;
        if (tx_pos == POS_W'(3 * SET_BITS + CBIT_END + SLOT - 1))
          jb = agg_out_data;
      end
    end
  endtask

  task automatic mon_sink(input int cyc);
    int g;
    g = 0;
    p = 0;
    z = 0;
    o = 0;
    gmin = 1000;
    gmax = 0;
    repeat (cyc)
    begin
      @(negedge sys_clk);
      g++;
      o += (tributary_data_out !== 1'b1);
      if (tributary_clock_out === 1'b1)
      begin
        p++;
        z += (tributary_data_out === 1'b0);
        if (p > 1 && g > gmax)
          gmax = g;
        if (p > 1 && g < gmin)
          gmin = g;
        g = 0;
      end
    end
  endtask

  task automatic t_idle();
    mon_frame();
    chk("idle source bits", 0, n_own);
    mon_sink(2000);
    chk("idle sink data", 0, o);
  endtask

  task automatic t_regs();
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl back", 32'h3, rd);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped err", 1, rerr);
    chk("unmapped data", 32'h0, rd);
  endtask

  task automatic t_src(input logic just);
    mon_frame();
    chk("slot bits", 381, n_own);
    chk("foreign bits", 0, n_bad);
    chk("control group", {3{just}}, cb);
    chk("j bit", just, jb);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status just", just, rd[ST_JUST]);
  endtask

  task automatic t_sink();
    mon_sink(6000);
    chk("sink zeros", p, z);
    chk("sink rate", 1, p >= 180 && p <= 230);
    chk("sink spacing", 1, gmax - gmin <= 2);
  endtask

  task automatic t_ais();
    @(posedge sys_clk);
    trail_signal_fail_in <= 1'b1;
    @(negedge sys_clk);
    chk("ssf set", 1, server_signal_fail_out);
    chk("ais set", 1, ais_insert_action);
    mon_sink(300);
    chk("ais ones", 0, o);
    apb(1'b0, 8'h04, 32'h0);
    chk("status ssf", 1, rd[ST_SSF]);
    trail_signal_fail_in <= 1'b0;
    @(negedge sys_clk);
    chk("ssf clear", 0, server_signal_fail_out);
    mon_sink(300);
    chk("data back", 1, z > 0);
  endtask

  task automatic t_off();
    apb(1'b1, 8'h00, 32'h1);
    trail_signal_fail_in <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk("quiet status", 0, rd[ST_SSF]);
    mon_sink(300);
    chk("off ones", 0, o);
  endtask

  initial
  begin
    #400000;
    err_total++;
    test_done();
  end

  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_idle();
    t_regs();
    // Slow tributary keeps the source store low: every frame justifies
    t_src(1'b1);
    trib_fast <= 1'b1;
    repeat (FRAME_BITS * 14) @(posedge sys_clk);
    t_src(1'b0);
    t_sink();
    t_ais();
    t_off();
    test_done();
  end
endmodule // tributary_justification_adapter_tb
